// File: rtl/scan_adc_regs.vh
`ifndef SCAN_ADC_REGS_VH
`define SCAN_ADC_REGS_VH

// Operating mode codes
`define MODE_AUTO        3'h0
`define MODE_POLL        3'h1
`define MODE_TIMED       3'h2
`define MODE_LOCAL       3'h3
`define MODE_REMOTE      3'h4
`define MODE_GAIN_LOAD   3'h5

// Gain codes
`define GAIN_X1          2'h0
`define GAIN_X10         2'h1
`define GAIN_X100        2'h2
`define GAIN_RESET       2'h0

// Buffer shape
`define NUM_CHANNELS     7'h40
`define BUF_DEPTH        5'h10
`define MID_SCAN_DEPTH   4'h7
`define LAST_DEPTH       4'hF

// Timing
`define CLK_HZ           32'h0773_5940
`define CLK_PERIOD_NS    32'h0000_0008
`define CONV_RATE_HZ     32'h0000_E290
`define MIN_CONV_CYC     ((`CLK_HZ + `CONV_RATE_HZ - 32'h0000_0001) / `CONV_RATE_HZ)
`define TRIG_OUT_NS      32'h0000_03E8
`define TRIG_OUT_CYC     (`TRIG_OUT_NS / `CLK_PERIOD_NS)

// Address window and modifier codes
`define WINDOW_SHIFT     4'hC
`define AM_A16_USER      6'h29
`define AM_A16_SUP       6'h2D
`define AM_A24_USER_DATA 6'h39
`define AM_A24_USER_PROG 6'h3A
`define AM_A24_SUP_DATA  6'h3D
`define AM_A24_SUP_PROG  6'h3E

`endif

// File: rtl/result_buffer.v
`timescale 1ns/1ps
`default_nettype none

module result_buffer #(
  parameter DW = 16,
  parameter AW = 10
) (
  input  wire          ref_clk,
  input  wire          nrst,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data,
  output reg           rd_valid
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Separate ports so host reads never wait on acquisition
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data  <= {DW{1'b0}};
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= mem[rd_addr];
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/scanning_adc_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "scan_adc_regs.vh"

module scanning_adc_sequencer #(
  parameter DATA_W = 16,
  parameter ADC_W  = 14
) (
  input  wire              ref_clk,
  input  wire              nrst,
  input  wire              soft_reset,
  input  wire [2:0]        mode_sel,
  input  wire [1:0]        block_sel,
  input  wire [15:0]       conv_period,
  input  wire [31:0]       burst_interval,
  input  wire              timed_repeat,
  input  wire              start_req,
  input  wire [5:0]        poll_chan,
  input  wire              gain_wr,
  input  wire [5:0]        gain_wr_chan,
  input  wire [1:0]        gain_wr_code,
  input  wire              coding_twos,
  input  wire              irq_en,
  input  wire              irq_ack,
  input  wire              ready_clr,
  input  wire              buf_rd_en,
  input  wire [9:0]        buf_rd_addr,
  input  wire              trig_in,
  input  wire              adc_done,
  input  wire [ADC_W-1:0]  adc_data,
  input  wire              vme_as_n,
  input  wire [23:0]       vme_addr,
  input  wire [5:0]        vme_am,
  input  wire [11:0]       jmp_base,
  input  wire              jmp_a24,
  input  wire              jmp_sup_en,
  input  wire              jmp_user_en,
  input  wire              jmp_data_en,
  input  wire              jmp_prog_en,
  input  wire              jmp_autogain,
  input  wire [1:0]        jmp_gain,
  output wire [DATA_W-1:0] buf_rd_data,
  output wire              buf_rd_valid,
  output reg  [DATA_W-1:0] converter_data_register,
  output reg               cdr_valid,
  output reg               adc_start,
  output reg  [5:0]        mux_chan,
  output reg  [1:0]        pga_gain,
  output reg               trig_out,
  output reg               irq,
  output reg               data_ready,
  output reg               burst_busy,
  output reg               board_sel
);

  localparam SW = 67;
  localparam ST_IDLE  = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_CONV  = 4'b0100;
  localparam ST_STORE = 4'b1000;
  localparam [31:0] MIN_CYC  = `MIN_CONV_CYC;
  localparam [31:0] TRIG_CYC = `TRIG_OUT_CYC;

  function am_ok;
    input [5:0] am;
    input       a24;
    input       sup;
    input       user;
    input       dat;
    input       prog;
    begin
      if (a24) begin
        am_ok = (am == `AM_A24_USER_DATA && user && dat) ||
                (am == `AM_A24_USER_PROG && user && prog) ||
                (am == `AM_A24_SUP_DATA  && sup  && dat) ||
                (am == `AM_A24_SUP_PROG  && sup  && prog);
      end else begin
        am_ok = (am == `AM_A16_USER && user && dat) ||
                (am == `AM_A16_SUP  && sup  && dat);
      end
    end
  endfunction

  // Every pin passes two flops before use
  reg  [SW-1:0] sync1;
  reg  [SW-1:0] sync2;
  wire [SW-1:0] pins = {trig_in, adc_done, adc_data, vme_as_n, vme_addr, vme_am, jmp_base, jmp_a24,
                        jmp_sup_en, jmp_user_en, jmp_data_en, jmp_prog_en, jmp_autogain, jmp_gain};

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= {SW{1'b0}};
      sync2 <= {SW{1'b0}};
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  wire             s_trig     = sync2[66];
  wire             s_done     = sync2[65];
  wire [ADC_W-1:0] s_data     = sync2[64:51];
  wire             s_as_n     = sync2[50];
  wire [23:0]      s_addr     = sync2[49:26];
  wire [5:0]       s_am       = sync2[25:20];
  wire [11:0]      s_base     = sync2[19:8];
  wire             s_a24      = sync2[7];
  wire             s_sup      = sync2[6];
  wire             s_user     = sync2[5];
  wire             s_dat      = sync2[4];
  wire             s_prog     = sync2[3];
  wire             s_autogain = sync2[2];
  wire [1:0]       s_jgain    = sync2[1:0];

  reg  done_q;
  reg  trig_q;
  wire done_rise = s_done & ~done_q;
  wire trig_rise = s_trig & ~trig_q;

  // Window compare on the bits above the 4 KB boundary
  wire addr_hit = s_a24 ? (s_addr[23:`WINDOW_SHIFT] == s_base) : (s_addr[15:`WINDOW_SHIFT] == s_base[3:0]);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_q    <= 1'b0;
      trig_q    <= 1'b0;
      board_sel <= 1'b0;
    end else begin
      done_q    <= s_done;
      trig_q    <= s_trig;
      board_sel <= !s_as_n && addr_hit && am_ok(s_am, s_a24, s_sup, s_user, s_dat, s_prog);
    end
  end

  // Gain table
  reg [1:0] gain_tab [0:63];
  integer   gi;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (gi = 0; gi < 64; gi = gi + 1) begin
        gain_tab[gi] <= `GAIN_RESET;
      end
    end else if (soft_reset) begin
      for (gi = 0; gi < 64; gi = gi + 1) begin
        gain_tab[gi] <= `GAIN_RESET;
      end
    end else if (gain_wr && mode_sel == `MODE_GAIN_LOAD) begin
      gain_tab[gain_wr_chan] <= gain_wr_code;
    end
  end

  reg  [3:0]        state;
  reg  [2:0]        mode_q;
  reg  [5:0]        scan_chan;
  reg  [3:0]        depth;
  reg               burst_full;
  reg  [15:0]       pace_cnt;
  reg  [31:0]       tmr_cnt;
  reg               timed_fired;
  reg  [15:0]       trig_cnt;
  reg  [DATA_W-1:0] sample;
  reg               buf_we;
  reg  [9:0]        buf_wa;
  reg  [DATA_W-1:0] buf_wd;

  wire       is_auto   = (mode_sel == `MODE_AUTO);
  wire       is_poll   = (mode_sel == `MODE_POLL);
  wire       is_timed  = (mode_sel == `MODE_TIMED);
  wire       mode_chg  = (mode_sel != mode_q);
  wire [5:0] last_chan = {block_sel, 4'hF};
  wire [5:0] cur_chan  = is_poll ? poll_chan : scan_chan;
  wire       run       = is_auto || is_poll || burst_busy;
  wire       tmr_exp   = is_timed && (!timed_fired || timed_repeat) && (tmr_cnt == 32'h0000_0000);
  wire       go_local  = (mode_sel == `MODE_LOCAL) && start_req;
  wire       go_remote = (mode_sel == `MODE_REMOTE) && trig_rise;
  wire       go_any    = go_local || go_remote || tmr_exp;
  wire       start_brs = go_any && !burst_busy && !mode_chg;
  wire [15:0] pace_len = (conv_period < MIN_CYC[15:0]) ? MIN_CYC[15:0] : conv_period;
  wire [DATA_W-1:0] conv_word = {s_data[ADC_W-1] ^ coding_twos, s_data[ADC_W-2:0], 2'b00};
  wire       scan_end  = (scan_chan == last_chan);

  // Triggers and timer
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_cnt     <= 32'h0000_0000;
      timed_fired <= 1'b0;
      trig_cnt    <= 16'h0000;
      trig_out    <= 1'b0;
    end else begin
      if (soft_reset || mode_chg) begin
        tmr_cnt     <= burst_interval;
        timed_fired <= 1'b0;
      end else if (is_timed) begin
        if (tmr_cnt == 32'h0000_0000) begin
          tmr_cnt <= burst_interval;
          if (tmr_exp) begin
            timed_fired <= 1'b1;
          end
        end else if (!timed_fired || timed_repeat) begin
          tmr_cnt <= tmr_cnt - 32'h0000_0001;
        end
      end
      // Mode switch leaves a running trigger pulse whole; a runt may be missed downstream
      if (soft_reset) begin
        trig_cnt <= 16'h0000;
        trig_out <= 1'b0;
      end else if (start_brs) begin
        trig_cnt <= TRIG_CYC[15:0];
        trig_out <= 1'b1;
      end else if (trig_cnt > 16'h0001) begin
        trig_cnt <= trig_cnt - 16'h0001;
      end else begin
        trig_cnt <= 16'h0000;
        trig_out <= 1'b0;
      end
    end
  end

  // Acquisition sequencer
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_IDLE;
      mode_q     <= `MODE_AUTO;
      scan_chan  <= 6'h00;
      depth      <= 4'h0;
      burst_full <= 1'b0;
      burst_busy <= 1'b0;
      pace_cnt   <= 16'h0000;
      sample     <= {DATA_W{1'b0}};
      adc_start  <= 1'b0;
      mux_chan   <= 6'h00;
      pga_gain   <= `GAIN_X1;
      buf_we     <= 1'b0;
      buf_wa     <= 10'h000;
      buf_wd     <= {DATA_W{1'b0}};
      converter_data_register <= {DATA_W{1'b0}};
      cdr_valid  <= 1'b0;
      irq        <= 1'b0;
      data_ready <= 1'b0;
    end else if (soft_reset || mode_chg) begin
      // Abandon any conversion in flight on a mode switch
      state      <= ST_IDLE;
      mode_q     <= soft_reset ? `MODE_AUTO : mode_sel;
      scan_chan  <= 6'h00;
      depth      <= 4'h0;
      burst_busy <= 1'b0;
      adc_start  <= 1'b0;
      buf_we     <= 1'b0;
      cdr_valid  <= 1'b0;
      if (soft_reset) begin
        irq        <= 1'b0;
        data_ready <= 1'b0;
      end
    end else begin
      buf_we    <= 1'b0;
      cdr_valid <= 1'b0;
      if (irq_ack) begin
        irq <= 1'b0;
      end
      if (ready_clr) begin
        data_ready <= 1'b0;
      end
      if (pace_cnt != 16'h0000) begin
        pace_cnt <= pace_cnt - 16'h0001;
      end
      if (start_brs) begin
        burst_busy <= 1'b1;
        burst_full <= !go_remote;
        scan_chan  <= 6'h00;
        depth      <= 4'h0;
      end
      case (state)
        ST_IDLE: begin
          if (run && !start_brs && pace_cnt == 16'h0000) begin
            mux_chan <= cur_chan;
            pga_gain <= s_autogain ? gain_tab[cur_chan] : s_jgain;
            pace_cnt <= pace_len;
            state    <= ST_START;
          end
        end
        ST_START: begin
          adc_start <= 1'b1;
          state     <= ST_CONV;
        end
        ST_CONV: begin
          adc_start <= 1'b0;
          if (done_rise) begin
            sample <= conv_word;
            state  <= ST_STORE;
          end
        end
        ST_STORE: begin
          state <= ST_IDLE;
          if (is_poll) begin
            converter_data_register <= sample;
            cdr_valid               <= 1'b1;
          end else begin
            buf_we <= 1'b1;
            buf_wa <= {scan_chan, depth};
            buf_wd <= sample;
            if (!scan_end) begin
              scan_chan <= scan_chan + 6'h01;
            end else begin
              scan_chan <= 6'h00;
              if (is_auto) begin
                data_ready <= 1'b1;
              end else if (!burst_full || depth == `LAST_DEPTH) begin
                burst_busy <= 1'b0;
                depth      <= 4'h0;
                data_ready <= 1'b1;
                if (irq_en) begin
                  irq <= 1'b1;
                end
              end else begin
                depth <= depth + 4'h1;
                if (depth == `MID_SCAN_DEPTH) begin
                  data_ready <= 1'b1;
                end
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  result_buffer #(
    .DW (DATA_W),
    .AW (10)
  ) u_buf (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr_en    (buf_we),
    .wr_addr  (buf_wa),
    .wr_data  (buf_wd),
    .rd_en    (buf_rd_en),
    .rd_addr  (buf_rd_addr),
    .rd_data  (buf_rd_data),
    .rd_valid (buf_rd_valid)
  );

endmodule

`default_nettype wire

// File: sim/adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input  wire logic        ref_clk,
  input  wire logic        adc_start,
  input  wire logic [5:0]  mux_chan,
  output var  logic        adc_done,
  output var  logic [13:0] adc_data
);
  logic [5:0] chan;
  int         cnt;
  initial begin
    adc_done = 1'h0;
    adc_data = 14'h0000;
    cnt = 0;
  end
  // Code encodes the channel so the bench can tell results apart
  always @(posedge ref_clk) begin
    if (adc_start) begin
      chan <= mux_chan;
      cnt <= 1;
    end else if (cnt != 0) begin
      cnt <= cnt + 1;
    end
    if (cnt == 30) begin
      adc_done <= 1'h1;
      adc_data <= {2'h2, chan, 6'h2A};
    end
    // Data no longer held once done drops
    if (cnt == 34) begin
      adc_done <= 1'h0;
      adc_data <= ~adc_data;
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// File: sim/seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module seq_props (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [2:0] mode_sel,
  input wire logic [1:0] block_sel,
  input wire logic       buf_rd_en,
  input wire logic       buf_rd_valid,
  input wire logic       cdr_valid,
  input wire logic       adc_start,
  input wire logic [5:0] mux_chan,
  input wire logic [1:0] pga_gain,
  input wire logic       trig_out,
  input wire logic       data_ready,
  input wire logic       burst_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [11:0] gap;
  logic [7:0]  hi;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gap <= 12'hFFF;
      hi <= 8'h00;
    end else begin
      gap <= adc_start ? 12'h001 : (gap == 12'hFFF ? gap : gap + 12'h001);
      hi <= trig_out ? hi + 8'h01 : 8'h00;
    end
  end
  sequence s_gain_mode;
    (mode_sel == 3'h5) [*3];
  endsequence
  sequence s_burst_start;
    $rose(burst_busy);
  endsequence
  AST_ADC_PULSE: assert property (adc_start |=> !adc_start) else $error("adc_start longer than one cycle");
  AST_PACE: assert property (adc_start |-> gap >= 12'h86C) else $error("conversions too close");
  AST_MUX_HOLD: assert property (adc_start |-> $stable(mux_chan) && $stable(pga_gain))
    else $error("mux or gain moved at start");
  AST_BLOCK: assert property (adc_start && mode_sel != 3'h1 |-> mux_chan[5:4] <= block_sel)
    else $error("channel outside block");
  AST_GAIN_MODE: assert property (s_gain_mode |-> !adc_start) else $error("conversion in gain loading");
  AST_TRIG_WIDTH: assert property ($fell(trig_out) |-> hi == 8'h7D) else $error("trigger width wrong");
  AST_TRIG_BUSY: assert property (s_burst_start |-> trig_out) else $error("burst without trigger out");
  AST_READY_END: assert property ($fell(burst_busy) && mode_sel == 3'h4 |-> ##[0:1] data_ready)
    else $error("no data ready at burst end");
  AST_RD_ANS: assert property (buf_rd_en |=> buf_rd_valid) else $error("read not answered");
  AST_CDR_PULSE: assert property (cdr_valid |=> !cdr_valid) else $error("cdr_valid too long");
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, nrst, soft_reset, timed_repeat, start_req, gain_wr, coding_twos, irq_en, irq_ack;
  logic ready_clr, buf_rd_en, trig_in, adc_done, vme_as_n, jmp_a24, jmp_sup_en, jmp_user_en;
  logic jmp_data_en, jmp_prog_en, jmp_autogain, cdr_valid, adc_start, trig_out, irq, data_ready;
  logic burst_busy, board_sel, buf_rd_valid;
  logic [2:0]  mode_sel;
  logic [1:0]  block_sel, gain_wr_code, jmp_gain, pga_gain;
  logic [15:0] conv_period, buf_rd_data, converter_data_register;
  logic [31:0] burst_interval;
  logic [5:0]  poll_chan, gain_wr_chan, vme_am, mux_chan;
  logic [9:0]  buf_rd_addr;
  logic [13:0] adc_data;
  logic [23:0] vme_addr;
  logic [11:0] jmp_base;
  int          mismatches, check_count, cycles;
  scanning_adc_sequencer i_scanning_adc_sequencer (.ref_clk(ref_clk), .nrst(nrst), .soft_reset(soft_reset),
    .mode_sel(mode_sel), .block_sel(block_sel), .conv_period(conv_period), .burst_interval(burst_interval),
    .timed_repeat(timed_repeat), .start_req(start_req), .poll_chan(poll_chan), .gain_wr(gain_wr),
    .gain_wr_chan(gain_wr_chan), .gain_wr_code(gain_wr_code), .coding_twos(coding_twos), .irq_en(irq_en),
    .irq_ack(irq_ack), .ready_clr(ready_clr), .buf_rd_en(buf_rd_en), .buf_rd_addr(buf_rd_addr),
    .trig_in(trig_in), .adc_done(adc_done), .adc_data(adc_data), .vme_as_n(vme_as_n), .vme_addr(vme_addr),
    .vme_am(vme_am), .jmp_base(jmp_base), .jmp_a24(jmp_a24), .jmp_sup_en(jmp_sup_en),
    .jmp_user_en(jmp_user_en), .jmp_data_en(jmp_data_en), .jmp_prog_en(jmp_prog_en),
    .jmp_autogain(jmp_autogain), .jmp_gain(jmp_gain), .buf_rd_data(buf_rd_data), .buf_rd_valid(buf_rd_valid),
    .converter_data_register(converter_data_register), .cdr_valid(cdr_valid), .adc_start(adc_start),
    .mux_chan(mux_chan), .pga_gain(pga_gain), .trig_out(trig_out), .irq(irq), .data_ready(data_ready),
    .burst_busy(burst_busy), .board_sel(board_sel));
  adc_model i_adc_model (.ref_clk(ref_clk), .adc_start(adc_start), .mux_chan(mux_chan),
    .adc_done(adc_done), .adc_data(adc_data));
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait: 0 start, 1 poll result, 2 busy, 3 idle
  task automatic wait_for(input int which, input int lim);
    int n;
    n = 0;
    while (n < lim && !(which == 0 ? adc_start : which == 1 ? cdr_valid : which == 2 ? burst_busy : !burst_busy)) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // Leaves the read strobe up so reads can run back to back
  task automatic rd(input logic [9:0] a, input logic [15:0] exp);
    buf_rd_en = 1'h1;
    buf_rd_addr = a;
    @(negedge ref_clk);
    chk("buf_rd_valid", {15'h0000, buf_rd_valid}, 16'h0001);
    chk("buf_rd_data", buf_rd_data, exp);
  endtask
  task automatic t_reset;
    chk("burst_busy", {15'h0000, burst_busy}, 16'h0000);
    chk("flags", {14'h0000, irq, data_ready}, 16'h0000);
    wait_for(0, 3000);
    chk("mux_chan", {10'h000, mux_chan}, 16'h0000);
    chk("pga_gain", {14'h0000, pga_gain}, 16'h0000);
    @(negedge ref_clk);
    wait_for(0, 3000);
    chk("mux_chan", {10'h000, mux_chan}, 16'h0001);
  endtask
  task automatic t_board;
    vme_as_n = 1'h0;
    repeat (5) @(negedge ref_clk);
    chk("board_sel", {15'h0000, board_sel}, 16'h0001);
    vme_am = 6'h3E;
    repeat (5) @(negedge ref_clk);
    chk("board_sel", {15'h0000, board_sel}, 16'h0000);
    vme_am = 6'h3D;
    vme_addr = 24'h12_4456;
    repeat (5) @(negedge ref_clk);
    chk("board_sel", {15'h0000, board_sel}, 16'h0000);
  endtask
  task automatic t_poll(input logic twos);
    coding_twos = twos;
    mode_sel = 3'h1;
    poll_chan = 6'h05;
    repeat (2) begin
      @(negedge ref_clk);
      wait_for(1, 6000);
    end
    chk("cdr", converter_data_register, {~twos, 7'h05, 6'h2A, 2'h0});
  endtask
  task automatic t_gain;
    poll_chan = 6'h09;
    for (int c = 2; c >= 0; c--) begin
      mode_sel = 3'h5;
      repeat (4) @(negedge ref_clk);
      gain_wr = 1'h1;
      gain_wr_code = c[1:0];
      @(negedge ref_clk);
      gain_wr = 1'h0;
      mode_sel = 3'h1;
      wait_for(0, 5000);
      chk("mux_chan", {10'h000, mux_chan}, 16'h0009);
      chk("pga_gain", {14'h0000, pga_gain}, {14'h0000, c[1:0]});
      @(negedge ref_clk);
    end
  endtask
  task automatic t_burst;
    mode_sel = 3'h3;
    @(negedge ref_clk);
    start_req = 1'h1;
    @(negedge ref_clk);
    start_req = 1'h0;
    chk("burst_busy", {15'h0000, burst_busy}, 16'h0001);
    chk("trig_out", {15'h0000, trig_out}, 16'h0001);
    mode_sel = 3'h2;
    repeat (200) @(negedge ref_clk);
    chk("burst_busy", {15'h0000, burst_busy}, 16'h0000);
    wait_for(2, 200);
    chk("burst_busy", {15'h0000, burst_busy}, 16'h0001);
    chk("trig_out", {15'h0000, trig_out}, 16'h0001);
    mode_sel = 3'h3;
    repeat (10) @(negedge ref_clk);
    chk("trig_out", {15'h0000, trig_out}, 16'h0001);
    repeat (120) @(negedge ref_clk);
    chk("trig_out", {15'h0000, trig_out}, 16'h0000);
  endtask
  task automatic pulse_trig;
    trig_in = 1'h1;
    repeat (4) @(negedge ref_clk);
    trig_in = 1'h0;
  endtask
  task automatic t_remote;
    mode_sel = 3'h4;
    repeat (10) @(negedge ref_clk);
    pulse_trig();
    wait_for(2, 10);
    chk("trig_out", {15'h0000, trig_out}, 16'h0001);
    repeat (20) @(negedge ref_clk);
    pulse_trig();
    repeat (120) @(negedge ref_clk);
    chk("trig_out", {15'h0000, trig_out}, 16'h0000);
    wait_for(3, 40000);
    chk("flags", {14'h0000, irq, data_ready}, 16'h0003);
    rd(10'h030, 16'h03A8);
    rd(10'h0F0, 16'h0FA8);
    buf_rd_en = 1'h0;
    irq_ack = 1'h1;
    ready_clr = 1'h1;
    repeat (2) @(negedge ref_clk);
    irq_ack = 1'h0;
    ready_clr = 1'h0;
    chk("flags", {14'h0000, irq, data_ready}, 16'h0000);
    pulse_trig();
    wait_for(2, 10);
    chk("burst_busy", {15'h0000, burst_busy}, 16'h0001);
    mode_sel = 3'h0;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    {nrst, soft_reset, timed_repeat, start_req, gain_wr, irq_ack, ready_clr, buf_rd_en, trig_in} = 9'h000;
    {coding_twos, irq_en, jmp_a24, jmp_sup_en, jmp_user_en, jmp_data_en, jmp_autogain, vme_as_n} = 8'hFF;
    {jmp_prog_en, mode_sel, block_sel, gain_wr_code, jmp_gain} = 10'h000;
    conv_period = 16'h0000;
    burst_interval = 32'h0000_0100;
    poll_chan = 6'h00;
    gain_wr_chan = 6'h09;
    vme_am = 6'h3D;
    vme_addr = 24'h12_3456;
    jmp_base = 12'h123;
    buf_rd_addr = 10'h000;
    {mismatches, check_count, cycles} = '0;
    repeat (3) @(negedge ref_clk);
    nrst = 1'h1;
    t_reset();
    t_board();
    t_poll(1'h0);
    t_poll(1'h1);
    t_gain();
    t_burst();
    t_remote();
    final_report();
  end
endmodule
bind scanning_adc_sequencer seq_props i_seq_props (.ref_clk(ref_clk), .nrst(nrst), .mode_sel(mode_sel),
  .block_sel(block_sel), .buf_rd_en(buf_rd_en), .buf_rd_valid(buf_rd_valid), .cdr_valid(cdr_valid),
  .adc_start(adc_start), .mux_chan(mux_chan), .pga_gain(pga_gain), .trig_out(trig_out),
  .data_ready(data_ready), .burst_busy(burst_busy));
`default_nettype wire
